//--- rtl/pmc_cfg.svh
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
`define PMC_OFF_SYSCLK 4'h0
`define PMC_OFF_FOSC 4'h4
`define PMC_OFF_STATUS 4'h8
`define PMC_OFF_WAKE 4'hC
`define PMC_SEL_HI 7
`define PMC_SEL_LO 5
`define PMC_FHID_BIT 1
`define PMC_FSID_BIT 0
`define PMC_FEN_BIT 0
`define PMC_FSTB_BIT 1
`define PMC_PDF_BIT 0
`define PMC_TO_BIT 1
`define PMC_SEL_SUB 3'h7
`define PMC_SEL_RST 3'h0
`define PMC_FEN_RST 1'b1
`define PMC_WAKE_RST 8'h00
`define PMC_SWITCH_PERIODS 3'h4
`define PMC_IRQ_NUM 4
`define PMC_PA_NUM 8
`endif

//--- rtl/pmc_pkg.sv
package pmc_pkg;
   typedef enum logic [1:0] {
      M_RUN = 2'b00,
      M_SWITCH = 2'b01,
      M_STANDBY = 2'b10,
      M_WAKE = 2'b11
   } mode_t;

   typedef struct packed {
      logic fast_clk;
      logic slow_clk;
      logic fast_ready;
      logic slow_ready;
      logic [7:0] porta;
   } pins_t;

   typedef struct packed {
      logic [5:0] cnt;
   } div_state_t;

   typedef struct packed {
      mode_t mode;
      logic [2:0] sel;
      logic [2:0] cur;
      logic [2:0] cnt;
      logic fhid;
      logic fsid;
      logic fen;
      logic frun;
      logic fstable;
      logic powerdown_flag;
      logic to;
      logic [7:0] wake_en;
      logic [7:0] pa_prev;
      logic [3:0] irq_block;
      logic fast_prev;
      logic sub_prev;
      logic w_wdt;
      logic w_vec;
      logic a_act;
      logic a_wr;
      logic a_hit;
      logic [3:0] a_off;
      logic [31:0] rdata;
      logic wdt_clr;
      logic resume;
      logic vector;
      logic pcsp;
   } pmc_state_t;
endpackage

//--- rtl/pmc_sync.sv
module pmc_sync #(
   parameter int W = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_state_t;

   sync_state_t s;
   sync_state_t n;

   always_comb begin
      n.s1 = d;
      n.s2 = s.s1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign q = s.s2;
endmodule // pmc_sync

//--- rtl/pmc_fast_divider.sv
module pmc_fast_divider import pmc_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic fast_edge,
   output logic [6:0] div_tick
);
   div_state_t s;
   div_state_t n;

   always_comb begin
      n = s;
      if (fast_edge) begin
         n.cnt = s.cnt + 6'h01;
      end
   end

   // ratio 2^k fires on the edge that wraps the low k bits
   always_comb begin
      div_tick[0] = fast_edge;
      for (int k = 1; k < 7; k++) begin
         div_tick[k] = fast_edge & (&(s.cnt | ~(6'h3F >> (6 - k))));
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end
endmodule // pmc_fast_divider

//--- rtl/power_mode_controller.sv
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`include "pmc_cfg.svh"

module power_mode_controller import pmc_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire pins_t pins,
   input wire logic halt_req,
   input wire logic clr_wdt,
   input wire logic wdt_enable,
   input wire logic wdt_overflow,
   input wire logic [3:0] irq_req,
   input wire logic [3:0] irq_enable,
   input wire logic stack_full,
   output logic fast_osc_run,
   output logic slow_osc_run,
   output logic sys_tick,
   output logic cpu_tick,
   output logic fast_tick,
   output logic sub_tick,
   output logic cpu_run,
   output logic hold_state,
   output logic wdt_clear,
   output logic wdt_run,
   output logic resume_next,
   output logic irq_vector,
   output logic pc_sp_reset
);
   pmc_state_t s;
   pmc_state_t n;
   pins_t pin_s;
   logic [6:0] div_tick;
   logic fast_edge;
   logic sub_edge;
   logic standby;
   logic cur_tick;
   logic xfer;
   logic wake_pa;
   logic [3:0] irq_new;
   logic [31:0] rd_val;

   function automatic logic src_tick(input logic [2:0] src, input logic [6:0] div,
                                     input logic sub);
      if (src == `PMC_SEL_SUB) begin
         return sub;
      end
      return div[src];
   endfunction

   function automatic logic src_ok(input logic [2:0] src, input logic slow_rdy,
                                   input logic fast_stb);
      return (src == `PMC_SEL_SUB) ? slow_rdy : fast_stb;
   endfunction

   function automatic logic src_kept(input logic [2:0] src, input logic fh,
                                     input logic fs);
      return (src == `PMC_SEL_SUB) ? fs : fh;
   endfunction

   pmc_sync #(
      .W(12)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(pins),
      .q(pin_s)
   );

   assign fast_edge = pin_s.fast_clk & ~s.fast_prev;
   assign sub_edge = pin_s.slow_clk & ~s.sub_prev;

   pmc_fast_divider u_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .fast_edge(fast_edge),
      .div_tick(div_tick)
   );

   assign standby = (s.mode == M_STANDBY) || (s.mode == M_WAKE);
   assign cur_tick = src_tick(s.cur, div_tick, sub_edge);
   assign xfer = hsel & htrans[1] & hready;
   // pin wake: falling edge on an enabled pin
   assign wake_pa = |(s.wake_en & s.pa_prev & ~pin_s.porta);
   assign irq_new = irq_req & ~s.irq_block;

   always_comb begin
      rd_val = 32'h0000_0000;
      case (s.a_off)
         `PMC_OFF_SYSCLK: begin
            rd_val[`PMC_SEL_HI:`PMC_SEL_LO] = s.sel;
            rd_val[`PMC_FHID_BIT] = s.fhid;
            rd_val[`PMC_FSID_BIT] = s.fsid;
         end
         `PMC_OFF_FOSC: begin
            rd_val[`PMC_FEN_BIT] = s.fen;
            rd_val[`PMC_FSTB_BIT] = s.fstable;
         end
         `PMC_OFF_STATUS: begin
            rd_val[`PMC_PDF_BIT] = s.powerdown_flag;
            rd_val[`PMC_TO_BIT] = s.to;
            rd_val[3:2] = s.mode;
            rd_val[6:4] = s.cur;
         end
         `PMC_OFF_WAKE: begin
            rd_val[7:0] = s.wake_en;
         end
         default: begin
            rd_val = 32'h0000_0000;
         end
      endcase
      if (!s.a_hit) begin
         rd_val = 32'h0000_0000;
      end
   end

   always_comb begin
      n = s;
      n.wdt_clr = 1'b0;
      n.resume = 1'b0;
      n.vector = 1'b0;
      n.pcsp = 1'b0;
      n.fast_prev = pin_s.fast_clk;
      n.sub_prev = pin_s.slow_clk;
      n.pa_prev = pin_s.porta;

      // bus address phase is taken here, data phase acts next cycle
      n.a_act = xfer;
      n.a_wr = hwrite;
      n.a_hit = (haddr[31:4] == 28'h0000000);
      n.a_off = {haddr[3:2], 2'b00};
      if (s.a_act && s.a_wr && s.a_hit) begin
         case (s.a_off)
            `PMC_OFF_SYSCLK: begin
               n.sel = hwdata[`PMC_SEL_HI:`PMC_SEL_LO];
               n.fhid = hwdata[`PMC_FHID_BIT];
               n.fsid = hwdata[`PMC_FSID_BIT];
            end
            `PMC_OFF_FOSC: begin
               n.fen = hwdata[`PMC_FEN_BIT];
            end
            `PMC_OFF_WAKE: begin
               n.wake_en = hwdata[7:0];
            end
            default: begin
            end
         endcase
      end
      if (s.a_act && !s.a_wr) begin
         n.a_act = 1'b0;
         n.rdata = rd_val;
      end

      // stable flag drops while stopped or just restarted
      n.frun = fast_osc_run;
      n.fstable = fast_osc_run & s.frun & (s.fstable | pin_s.fast_ready);

      if (clr_wdt) begin
         n.powerdown_flag = 1'b0;
      end

      case (s.mode)
         M_RUN: begin
            if (halt_req) begin
               n.mode = M_STANDBY;
               n.powerdown_flag = 1'b1;
               n.to = 1'b0;
               n.wdt_clr = 1'b1;
               n.irq_block = irq_req;
            end else if (s.sel != s.cur) begin
               n.mode = M_SWITCH;
               n.cnt = 3'h0;
            end
         end
         M_SWITCH: begin
            // old source drives the system until the commit
            if (s.cnt != `PMC_SWITCH_PERIODS) begin
               if (cur_tick) begin
                  n.cnt = s.cnt + 3'h1;
               end
            end else if (s.sel == s.cur) begin
               n.mode = M_RUN;
            end else if (src_ok(s.sel, pin_s.slow_ready, s.fstable)
                         && src_tick(s.sel, div_tick, sub_edge)) begin
               n.cur = s.sel;
               n.mode = M_RUN;
            end
         end
         M_STANDBY: begin
            if (wdt_overflow) begin
               n.to = 1'b1;
               n.w_wdt = 1'b1;
               n.w_vec = 1'b0;
               n.mode = M_WAKE;
            end else if (wake_pa || (|irq_new)) begin
               n.w_wdt = 1'b0;
               n.w_vec = (|(irq_new & irq_enable)) & ~stack_full;
               n.mode = M_WAKE;
            end
         end
         M_WAKE: begin
            if (src_ok(s.cur, pin_s.slow_ready, s.fstable)) begin
               n.mode = M_RUN;
               n.pcsp = s.w_wdt;
               n.vector = s.w_vec;
               n.resume = ~s.w_wdt & ~s.w_vec;
            end
         end
         default: begin
            n.mode = M_RUN;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.mode <= M_RUN;
         s.sel <= `PMC_SEL_RST;
         s.cur <= `PMC_SEL_RST;
         s.fen <= `PMC_FEN_RST;
         s.wake_en <= `PMC_WAKE_RST;
      end else begin
         s <= n;
      end
   end

   // oscillator gating per standby kind; wake wait restarts the slow oscillator, and the fast one if fen is set
   always_comb begin
      if (s.mode == M_STANDBY) begin
         fast_osc_run = s.fhid;
         slow_osc_run = s.fsid | wdt_enable;
      end else begin
         fast_osc_run = s.fen;
         slow_osc_run = 1'b1;
      end
   end

   // whole source pulses only; gating never splits one
   assign sys_tick = cur_tick & src_ok(s.cur, pin_s.slow_ready, s.fstable)
                     & (~standby | src_kept(s.cur, s.fhid, s.fsid));
   assign cpu_run = ~standby;
   assign cpu_tick = sys_tick & cpu_run;
   assign fast_tick = fast_edge & s.fstable;
   assign sub_tick = sub_edge & (~standby | s.fsid);
   assign hold_state = standby;
   assign wdt_clear = s.wdt_clr;
   assign wdt_run = wdt_enable;
   assign resume_next = s.resume;
   assign irq_vector = s.vector;
   assign pc_sp_reset = s.pcsp;

   assign hreadyout = ~(s.a_act & ~s.a_wr);
   assign hrdata = s.rdata;
   assign hresp = 1'b0;
endmodule // power_mode_controller

//--- verification/pmc_chk.sv
module pmc_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic halt_req,
   input wire logic wdt_enable,
   input wire logic sys_tick,
   input wire logic cpu_tick,
   input wire logic cpu_run,
   input wire logic hold_state,
   input wire logic wdt_clear,
   input wire logic wdt_run,
   input wire logic resume_next,
   input wire logic irq_vector,
   input wire logic pc_sp_reset
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence rd_req;
      hsel && htrans[1] && !hwrite && hready;
   endsequence
   sequence rd_ans;
      !hreadyout ##1 hreadyout;
   endsequence
   a_read_wait: assert property (rd_req |=> rd_ans)
      else $error("read wait state wrong");
   a_resp_okay: assert property (!hresp)
      else $error("error response seen");
   a_halt_clear: assert property (wdt_clear |-> $past(halt_req))
      else $error("watchdog clear without halt");
   a_entry_hold: assert property ($rose(hold_state) |-> $past(halt_req))
      else $error("standby without halt");
   a_cpu_stop: assert property (cpu_run != hold_state)
      else $error("cpu runs in standby");
   a_tick_gate: assert property (cpu_tick |-> sys_tick && cpu_run)
      else $error("cpu tick not gated");
   a_wake_one: assert property ($onehot0({resume_next, irq_vector, pc_sp_reset}))
      else $error("several wake outcomes");
   a_wake_run: assert property (resume_next || irq_vector || pc_sp_reset |-> !hold_state)
      else $error("wake outcome while held");
   a_wdt_follow: assert property (wdt_run == wdt_enable)
      else $error("watchdog run wrong");
endmodule // pmc_chk

//--- verification/pmc_osc_model.sv
module pmc_osc_model (
   input wire logic hclk,
   input wire logic run_fast,
   input wire logic run_slow,
   output logic fclk,
   output logic sclk,
   output logic frdy,
   output logic srdy
);
   timeunit 1ns;
   timeprecision 1ns;
   int fc = 0;
   int sc = 0;
   initial begin
      {fclk, sclk, frdy, srdy} = 4'h0;
   end
   // stopped oscillators stand still; ready only after a start-up run
   always @(posedge hclk) begin
      fc <= run_fast ? fc + 1 : 0;
      sc <= run_slow ? sc + 1 : 0;
      fclk <= run_fast && fc[1];
      sclk <= run_slow && sc[3];
      frdy <= run_fast && fc > 16;
      srdy <= run_slow && sc > 24;
   end
endmodule // pmc_osc_model

//--- verification/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import pmc_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, halt_req = 1'b0;
   logic clr_wdt = 1'b0, wdt_enable = 1'b0, wdt_overflow = 1'b0, stack_full = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [3:0] irq_req = 4'h0, irq_enable = 4'h0;
   logic [7:0] porta = 8'hFF;
   logic hready, hreadyout, hresp, fclk, sclk, frdy, srdy, fast_osc_run, slow_osc_run;
   logic sys_tick, cpu_tick, cpu_run, hold_state, wdt_clear, wdt_run, fast_tick, sub_tick;
   logic resume_next, irq_vector, pc_sp_reset;
   logic [31:0] hrdata;
   pins_t pins;
   int n_fail = 0, n_checks = 0;
   assign hready = hreadyout;
   assign pins = {fclk, sclk, frdy, srdy, porta};
   always #10 hclk = ~hclk;
   power_mode_controller DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hrdata, .hresp, .pins, .halt_req, .clr_wdt,
      .wdt_enable, .wdt_overflow, .irq_req, .irq_enable, .stack_full, .fast_osc_run,
      .slow_osc_run, .sys_tick, .cpu_tick, .fast_tick, .sub_tick, .cpu_run,
      .hold_state, .wdt_clear, .wdt_run, .resume_next, .irq_vector, .pc_sp_reset);
   pmc_osc_model osc (.hclk, .run_fast(fast_osc_run), .run_slow(slow_osc_run),
      .fclk, .sclk, .frdy, .srdy);
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= 1'b1;
      @(posedge hclk iff hready);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk iff hready);
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge hclk);
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= 1'b0;
      @(posedge hclk iff hready);
      htrans <= 2'b00;
      @(posedge hclk iff hready);
      d = hrdata;
   endtask
   task automatic halt();
      @(posedge hclk);
      halt_req <= 1'b1;
      @(posedge hclk);
      halt_req <= 1'b0;
      repeat (2) @(posedge hclk);
   endtask
   // waits for one wake outcome: {resume, vector, pc/sp reset}
   task automatic wake_wait(input logic [2:0] e);
      logic [2:0] p;
      p = 3'h0;
      for (int i = 0; i < 400 && p == 3'h0; i++) begin
         @(posedge hclk);
         p = {resume_next, irq_vector, pc_sp_reset};
      end
      chk(32'(p), 32'(e));
   endtask
   task automatic t_regs();
      logic [31:0] d;
      rd(32'h0, d);
      chk(d, 32'h0);
      rd(32'h4, d);
      chk(d, 32'h3);
      rd(32'h10, d);
      chk(d, 32'h0);
      wr(32'hC, 32'hA5);
      rd(32'hC, d);
      chk(d, 32'hA5);
      $display("done regs");
   endtask
   task automatic t_fosc();
      logic [31:0] d;
      wr(32'h4, 32'h0);
      @(posedge hclk);
      chk(32'(fast_osc_run), 32'h0);
      rd(32'h4, d);
      chk(d, 32'h0);
      wr(32'h4, 32'h1);
      rd(32'h4, d);
      chk(d, 32'h1);
      for (int i = 0; i < 50 && d != 32'h3; i++) begin
         rd(32'h4, d);
      end
      chk(d, 32'h3);
      $display("done fast enable");
   endtask
   task automatic t_switch();
      logic [31:0] d;
      logic [2:0] s;
      for (int k = 1; k <= 8; k++) begin
         s = 3'(k);
         wr(32'h0, {24'h0, s, 5'h0});
         rd(32'h8, d);
         chk(32'(d[6:2]), 32'({s - 3'h1, 2'b01}));
         for (int i = 0; i < 600 && d[6:2] != {s, 2'b00}; i++) begin
            rd(32'h8, d);
         end
         chk(32'(d[6:2]), 32'({s, 2'b00}));
      end
      $display("done switch");
   endtask
   task automatic t_halt(input logic [1:0] k);
      logic [31:0] d;
      int nf = 0;
      int ns = 0;
      wr(32'h0, {30'h0, k});
      wr(32'hC, 32'h1);
      halt();
      chk(32'(hold_state), 32'h1);
      chk(32'({fast_osc_run, slow_osc_run}), 32'(k));
      rd(32'h8, d);
      chk(d, 32'h9);
      porta <= 8'hFD;
      for (int i = 0; i < 20; i++) begin
         @(posedge hclk);
         nf += fast_tick;
         ns += sub_tick;
      end
      chk(32'(nf != 0), 32'(k[1]));
      chk(32'(ns != 0), 32'(k[0]));
      chk(32'(hold_state), 32'h1);
      porta <= 8'hFC;
      wake_wait(3'b100);
      porta <= 8'hFF;
      rd(32'h8, d);
      chk(32'(d[1:0]), 32'h1);
      $display("done halt %0d", k);
   endtask
   task automatic t_wdt();
      logic [31:0] d;
      @(posedge hclk);
      clr_wdt <= 1'b1;
      @(posedge hclk);
      clr_wdt <= 1'b0;
      rd(32'h8, d);
      chk(32'(d[0]), 32'h0);
      wdt_enable <= 1'b1;
      wr(32'h0, 32'h0);
      halt();
      chk(32'(slow_osc_run), 32'h1);
      wdt_overflow <= 1'b1;
      @(posedge hclk);
      wdt_overflow <= 1'b0;
      wake_wait(3'b001);
      rd(32'h8, d);
      chk(32'(d[1:0]), 32'h3);
      halt();
      rd(32'h8, d);
      chk(32'(d[1:0]), 32'h1);
      porta <= 8'hFE;
      wake_wait(3'b100);
      porta <= 8'hFF;
      wdt_enable <= 1'b0;
      $display("done watchdog");
   endtask
   task automatic t_irq();
      irq_enable <= 4'h1;
      irq_req <= 4'h2;
      halt();
      repeat (20) @(posedge hclk);
      chk(32'(hold_state), 32'h1);
      irq_req <= 4'h3;
      wake_wait(3'b010);
      for (int i = 0; i < 2; i++) begin
         irq_req <= 4'h0;
         stack_full <= (i == 0);
         halt();
         irq_req <= (i == 0) ? 4'h1 : 4'h4;
         wake_wait(3'b100);
      end
      irq_req <= 4'h0;
      $display("done interrupt");
   endtask
   initial begin
      #400000;
      n_fail++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (40) @(posedge hclk);
      t_regs();
      t_fosc();
      t_switch();
      for (int k = 0; k < 4; k++) begin
         t_halt(2'(k));
      end
      t_wdt();
      t_irq();
      end_sim();
   end
endmodule // testbench
bind power_mode_controller pmc_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
   .hready, .hreadyout, .hresp, .halt_req, .wdt_enable, .sys_tick, .cpu_tick, .cpu_run,
   .hold_state, .wdt_clear, .wdt_run, .resume_next, .irq_vector, .pc_sp_reset);
